// *** src/mac_pause_flow_control.sv ***
// full-duplex pause flow control with ahb-lite register access
//
// Contract
// - full-duplex pause: send and honour frames
// - auto pause when fifo level reaches threshold
// - auto pause time from auto register
// - repeat while level at or above threshold
// - stop repeating once retry limit reached
// - auto pause only while tx enable set
// - manual time write sends exactly one frame
// - no new frame until pause time elapses
// - frame already in progress is completed
// - honour received pause only when enabled
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module mac_pause_flow_control (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // receive fifo level from the dma unit
  input wire logic [mac_pause_pkg::LEVEL_W-1:0] i_rx_fifo_level,
  // received pause frames from the mac receiver
  input wire logic i_rx_pause_valid,
  input wire logic [mac_pause_pkg::TIME_W-1:0] i_rx_pause_time,
  // pause frame requests to the mac transmitter
  output logic o_pause_valid,
  input wire logic i_pause_ready,
  output logic [mac_pause_pkg::TIME_W-1:0] o_pause_time,
  // normal frame start gating
  input wire logic i_tx_frame_req,
  input wire logic i_tx_busy,
  output logic o_tx_start,
  output logic o_tx_hold
);
  import mac_pause_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [2:0] mode_ff; // mode control bits
  logic [LEVEL_W-1:0] threshold_ff; // flow start threshold
  logic [TIME_W-1:0] auto_time_ff; // auto pause time
  logic [15:0] retry_limit_ff; // zero means no limit
  logic [TIME_W-1:0] manual_time_ff; // last manual pause time
  logic manual_pend_ff; // manual frame waiting for a slot
  logic [15:0] sent_count_ff; // auto frames sent this episode
  auto_state_t auto_state_ff;
  auto_state_t nxt_auto_state;

  // ahb data-phase bookkeeping
  logic wr_phase_ff; // write data phase pending
  logic [7:0] wr_addr_ff; // latched write offset

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  logic addr_take; // valid address phase accepted
  logic wr_strobe; // write data present this cycle
  logic [31:0] rd_word;

  // zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign addr_take = i_hsel && i_hready
                     && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
  assign wr_strobe = wr_phase_ff;

  // latch address phase of writes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_phase_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_phase_ff <= addr_take && i_hwrite;
      if (addr_take) begin
        wr_addr_ff <= i_haddr[7:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = WORD_ZERO;
    unique case (i_haddr[7:0])
      OFS_MAC_MODE_CONTROL: rd_word[2:0] = mode_ff;
      OFS_FLOW_START_THRESHOLD: rd_word[LEVEL_W-1:0] = threshold_ff;
      OFS_AUTO_PAUSE_TIME: rd_word[TIME_W-1:0] = auto_time_ff;
      OFS_PAUSE_RETRY_LIMIT: rd_word[15:0] = retry_limit_ff;
      OFS_MANUAL_PAUSE_TIME: rd_word[TIME_W-1:0] = manual_time_ff;
      OFS_PAUSE_STATUS: begin
        rd_word[STAT_HOLD_BIT] = o_tx_hold;
        rd_word[STAT_AUTO_BUSY_BIT] = (auto_state_ff == AP_QUEUED);
        rd_word[STAT_HALTED_BIT] = (auto_state_ff == AP_HALTED);
        rd_word[STAT_MAN_PEND_BIT] = manual_pend_ff;
        rd_word[STAT_COUNT_LSB +: 16] = sent_count_ff;
      end
      default: rd_word = WORD_ZERO;
    endcase
  end

  // read data captured at the address phase, shown in the data phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hrdata <= WORD_ZERO;
    end else if (addr_take && !i_hwrite) begin
      o_hrdata <= rd_word;
    end
  end

  // software-written configuration
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_ff <= MODE_RESET;
      threshold_ff <= FIELD_RESET;
      auto_time_ff <= FIELD_RESET;
      retry_limit_ff <= FIELD_RESET;
      manual_time_ff <= FIELD_RESET;
    end else if (wr_strobe) begin
      unique case (wr_addr_ff)
        OFS_MAC_MODE_CONTROL: mode_ff <= i_hwdata[2:0];
        OFS_FLOW_START_THRESHOLD: threshold_ff <= i_hwdata[LEVEL_W-1:0];
        OFS_AUTO_PAUSE_TIME: auto_time_ff <= i_hwdata[TIME_W-1:0];
        OFS_PAUSE_RETRY_LIMIT: retry_limit_ff <= i_hwdata[15:0];
        OFS_MANUAL_PAUSE_TIME: manual_time_ff <= i_hwdata[TIME_W-1:0];
        default: ; // status and unmapped: ignored
      endcase
    end
  end

  // ------------------------------------------------------------
  // two-entry pause request buffer
  // ------------------------------------------------------------
  // each entry carries a tag telling auto from manual frames
  logic [TIME_W:0] buf_mem [0:1];
  logic buf_wptr_ff;
  logic buf_rptr_ff;
  logic [1:0] buf_count_ff;
  logic push_valid; // a request wants a slot
  logic push_ready; // buffer has room
  logic [TIME_W:0] push_data;
  logic push_fire;
  logic pop_fire;
  logic pop_is_auto;

  assign push_ready = (buf_count_ff != 2'd2);
  assign push_fire = push_valid && push_ready;
  assign o_pause_valid = (buf_count_ff != 2'd0);
  assign pop_fire = o_pause_valid && i_pause_ready;
  assign o_pause_time = buf_mem[buf_rptr_ff][TIME_W-1:0];
  assign pop_is_auto = buf_mem[buf_rptr_ff][TIME_W];

  // a stalled transmitter fills the buffer and then blocks new pushes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      buf_wptr_ff <= 1'b0;
      buf_rptr_ff <= 1'b0;
      buf_count_ff <= 2'd0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (push_fire) begin
        buf_mem[buf_wptr_ff] <= push_data;
        buf_wptr_ff <= ~buf_wptr_ff;
      end
      if (pop_fire) begin
        buf_rptr_ff <= ~buf_rptr_ff;
      end
      buf_count_ff <= buf_count_ff + 2'(push_fire) - 2'(pop_fire);
    end
  end

  // ------------------------------------------------------------
  // manual pause request
  // ------------------------------------------------------------
  logic manual_write; // software wrote the manual time register
  logic manual_push; // manual entry enters the buffer now
  logic auto_push; // auto entry enters the buffer now
  logic auto_want;
  logic above_thr;
  logic limit_hit;

  assign manual_write = wr_strobe && (wr_addr_ff == OFS_MANUAL_PAUSE_TIME);

  // one write arms exactly one frame; a new write wins over the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      manual_pend_ff <= 1'b0;
    end else if (manual_write) begin
      manual_pend_ff <= 1'b1;
    end else if (manual_push) begin
      manual_pend_ff <= 1'b0;
    end
  end

  // manual request has priority for the slot
  always_comb begin
    manual_push = manual_pend_ff && push_ready;
    auto_push = auto_want && push_ready && !manual_pend_ff;
    push_valid = manual_pend_ff || auto_want;
    if (manual_pend_ff) begin
      push_data = {1'b0, manual_time_ff};
    end else begin
      push_data = {1'b1, auto_time_ff};
    end
  end

  // ------------------------------------------------------------
  // automatic pause sequencer
  // ------------------------------------------------------------
  assign above_thr = (i_rx_fifo_level >= threshold_ff);
  assign limit_hit = (retry_limit_ff != 16'h0000)
                     && (sent_count_ff >= retry_limit_ff);
  // one auto frame in flight at a time, so repeats follow actual sends
  assign auto_want = (auto_state_ff == AP_IDLE) && above_thr
                     && mode_ff[MODE_AUTO_TX_EN_BIT] && !limit_hit;

  // next state of the sequencer
  always_comb begin
    nxt_auto_state = auto_state_ff;
    unique case (auto_state_ff)
      AP_IDLE: begin
        if (auto_push) begin
          nxt_auto_state = AP_QUEUED;
        end else if (limit_hit && above_thr) begin
          nxt_auto_state = AP_HALTED;
        end
      end
      AP_QUEUED: begin
        if (pop_fire && pop_is_auto) begin
          nxt_auto_state = AP_IDLE;
        end
      end
      AP_HALTED: begin
        if (!above_thr) begin
          nxt_auto_state = AP_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      auto_state_ff <= AP_IDLE;
    end else begin
      auto_state_ff <= nxt_auto_state;
    end
  end

  // count of auto frames sent; restarts once the fifo drains
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sent_count_ff <= 16'h0000;
    end else if (pop_fire && pop_is_auto) begin
      sent_count_ff <= sent_count_ff + 16'h0001;
    end else if (!above_thr && auto_state_ff != AP_QUEUED) begin
      sent_count_ff <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // received pause timer
  // ------------------------------------------------------------
  logic [9:0] q_cyc_ff; // cycles left in the current quantum
  logic [TIME_W-1:0] quanta_ff; // quanta left to wait
  logic q_tick; // one quantum elapsed
  logic rx_load; // accepted pause frame
  logic [9:0] q_len;

  // 512 bit times at the selected link speed
  assign q_len = mode_ff[MODE_SPEED_100_BIT] ? QUANTUM_CYC_100M
                                             : QUANTUM_CYC_10M;
  assign q_tick = (quanta_ff != FIELD_RESET) && (q_cyc_ff == 10'd1);
  assign rx_load = i_rx_pause_valid && mode_ff[MODE_RX_EN_BIT];

  // a new pause frame restarts the wait; time zero releases at once
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      quanta_ff <= FIELD_RESET;
      q_cyc_ff <= 10'd0;
    end else if (rx_load) begin
      quanta_ff <= i_rx_pause_time;
      q_cyc_ff <= q_len;
    end else if (quanta_ff != FIELD_RESET) begin
      if (q_tick) begin
        quanta_ff <= quanta_ff - 16'h0001;
        q_cyc_ff <= q_len;
      end else begin
        q_cyc_ff <= q_cyc_ff - 10'd1;
      end
    end
  end

  // hold blocks only new starts, a frame on the wire is never cut
  assign o_tx_hold = (quanta_ff != FIELD_RESET);
  assign o_tx_start = i_tx_frame_req && !o_tx_hold && !i_tx_busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_manual_armed;
    manual_write ##1 manual_pend_ff;
  endsequence

  sequence s_rx_accept;
    rx_load && (i_rx_pause_time != FIELD_RESET);
  endsequence

  chk_auto_needs_enable: assert property (
    auto_push |-> mode_ff[MODE_AUTO_TX_EN_BIT])
    else $error("auto pause pushed while disabled");

  chk_auto_time_source: assert property (
    auto_push |=> buf_mem[$past(buf_wptr_ff)] == {1'b1, $past(auto_time_ff)})
    else $error("auto pause time not from auto register");

  chk_auto_threshold: assert property (
    (auto_state_ff == AP_IDLE && above_thr && mode_ff[MODE_AUTO_TX_EN_BIT]
     && !limit_hit && push_ready && !manual_pend_ff) |=> o_pause_valid)
    else $error("auto pause missed at threshold");

  chk_below_no_auto: assert property (
    (i_rx_fifo_level < threshold_ff) |-> !auto_push)
    else $error("auto pause pushed below threshold");

  chk_limit_stops: assert property (
    limit_hit |-> !auto_push)
    else $error("auto pause pushed past retry limit");

  chk_manual_one: assert property (
    s_manual_armed |-> ##[0:8] manual_push ##1
      (!manual_pend_ff || $past(manual_write)))
    else $error("manual pause not queued once");

  chk_hold_after_rx: assert property (
    s_rx_accept |=> o_tx_hold ##0 !o_tx_start)
    else $error("transmit not held after pause frame");

  chk_rx_disabled: assert property (
    (i_rx_pause_valid && !mode_ff[MODE_RX_EN_BIT] && !o_tx_hold)
      |=> !o_tx_hold)
    else $error("pause frame honoured while disabled");

  chk_quantum_steady: assert property (
    (o_tx_hold && !rx_load && !q_tick) |=> quanta_ff == $past(quanta_ff))
    else $error("pause quanta changed mid quantum");

  chk_busy_no_start: assert property (
    i_tx_busy |-> !o_tx_start)
    else $error("new frame started during transmission");

endmodule : mac_pause_flow_control

// *** src/mac_pause_pkg.sv ***
// constants for the mac pause flow-control block
package mac_pause_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MAC_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FLOW_START_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_AUTO_PAUSE_TIME = 8'h08;
  localparam logic [7:0] OFS_PAUSE_RETRY_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_MANUAL_PAUSE_TIME = 8'h10;
  localparam logic [7:0] OFS_PAUSE_STATUS = 8'h14;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int MODE_AUTO_TX_EN_BIT = 0; // auto_pause_tx_enable
  localparam int MODE_RX_EN_BIT = 1; // pause_rx_enable
  localparam int MODE_SPEED_100_BIT = 2; // link speed select
  localparam int STAT_HOLD_BIT = 0; // transmit held by received pause
  localparam int STAT_AUTO_BUSY_BIT = 1; // auto pause outstanding
  localparam int STAT_HALTED_BIT = 2; // retry limit reached
  localparam int STAT_MAN_PEND_BIT = 3; // manual pause not yet queued
  localparam int STAT_COUNT_LSB = 16; // auto pause frames sent

  localparam int LEVEL_W = 16; // receive fifo level width
  localparam int TIME_W = 16; // pause-time field width

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [15:0] FIELD_RESET = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ------------------------------------------------------------
  // ahb-lite encodings
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // ------------------------------------------------------------
  // pause quantum timing: 512 bit times, rounded up to cycles
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint QUANTUM_BITS = 64'd512;
  localparam longint RATE_10M = 64'd10_000_000;
  localparam longint RATE_100M = 64'd100_000_000;
  localparam longint Q_CYC_10 = (QUANTUM_BITS * CLK_HZ + RATE_10M - 1)
                                / RATE_10M;
  localparam longint Q_CYC_100 = (QUANTUM_BITS * CLK_HZ + RATE_100M - 1)
                                 / RATE_100M;
  localparam logic [9:0] QUANTUM_CYC_10M = 10'(Q_CYC_10);
  localparam logic [9:0] QUANTUM_CYC_100M = 10'(Q_CYC_100);

  // auto pause sequencer, one-hot
  typedef enum logic [2:0] {
    AP_IDLE = 3'b001,
    AP_QUEUED = 3'b010,
    AP_HALTED = 3'b100
  } auto_state_t;

endpackage : mac_pause_pkg

// *** test/mac_pause_partner.sv ***
// partner model: mac transmitter and receiver beside the pause block
`timescale 1ns/1ns
module mac_pause_partner (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // pause request stream
  input wire logic i_stall,
  output logic o_pause_ready,
  // received pause frames
  output logic o_rx_pause_valid,
  output logic [15:0] o_rx_pause_time,
  // normal frame transmitter
  input wire logic i_tx_start,
  output logic o_tx_busy
);
  int busy_cnt; // cycles left of the frame on the wire

  // ready follows the stall request, so slow and prompt pops both occur
  assign o_pause_ready = !i_stall;
  assign o_tx_busy = (busy_cnt != 0);

  // a started frame runs its full length, never cut short
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_cnt <= 0;
    end else if (i_tx_start && busy_cnt == 0) begin
      busy_cnt <= 20;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end

  initial begin
    o_rx_pause_valid = 1'b0;
    o_rx_pause_time = 16'h0000;
  end

  // one-cycle frame pulse; time is scrambled outside it, never held
  task automatic send_pause(input logic [15:0] t);
    @(posedge i_sys_clk);
    o_rx_pause_valid <= 1'b1;
    o_rx_pause_time <= t;
    @(posedge i_sys_clk);
    o_rx_pause_valid <= 1'b0;
    o_rx_pause_time <= ~t;
  endtask : send_pause
endmodule : mac_pause_partner

// *** test/mac_pause_flow_control_tb_top.sv ***
// self-checking testbench of the pause flow-control block
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("MISMATCH %s exp=%0h got=%0h", nm, (e), (g)); \
    end \
  end
module mac_pause_flow_control_tb_top;
  import mac_pause_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, stall;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] level, rx_t, p_time, man_t, pt;
  logic rx_v, p_valid, p_ready, tx_req, tx_busy, tx_start, tx_hold;
  logic [15:0] exp_q[$]; // frames the model expects
  logic [15:0] got_q[$]; // frames popped at the ports
  int failures = 0;
  int num_checks = 0;
  int seed = 83;
  int n, cnt, bad, q;

  always #50 sys_clk = ~sys_clk;
  // random stalls on the pause stream
  always @(posedge sys_clk) stall <= (($random(seed) & 3) == 0);
  // record every pause frame handed over
  always @(posedge sys_clk) begin
    if (!rst && p_valid === 1'b1 && p_ready === 1'b1) begin
      got_q.push_back(p_time);
    end
  end

  mac_pause_flow_control uut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_rx_fifo_level(level),
    .i_rx_pause_valid(rx_v), .i_rx_pause_time(rx_t),
    .o_pause_valid(p_valid), .i_pause_ready(p_ready),
    .o_pause_time(p_time), .i_tx_frame_req(tx_req),
    .i_tx_busy(tx_busy), .o_tx_start(tx_start), .o_tx_hold(tx_hold));

  mac_pause_partner u_part (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_stall(stall),
    .o_pause_ready(p_ready), .o_rx_pause_valid(rx_v),
    .o_rx_pause_time(rx_t), .i_tx_start(tx_start), .o_tx_busy(tx_busy));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // one ahb-lite single transfer; waits on hready, never assumes it
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    `CHK(nm, e, r)
  endtask : rd_chk

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : wait_cyc

  // compare popped frames with the model, then start afresh
  task automatic check_frames();
    `CHK("frame_count", exp_q.size(), got_q.size())
    for (int k = 0; k < exp_q.size() && k < got_q.size(); k++) begin
      `CHK("frame_time", exp_q[k], got_q[k])
    end
    exp_q.delete();
    got_q.delete();
  endtask : check_frames

  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask : tend

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs little more than a thousand cycles
  initial begin
    #2_000_000;
    failures++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    level = 16'h0000;
    tx_req = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // every word reads zero after reset, unmapped ones included
    for (int k = 0; k <= 32; k += 4) begin
      rd_chk("reset_value", k[7:0], WORD_ZERO);
    end
    wr(OFS_FLOW_START_THRESHOLD, 32'h0000_0040);
    wr(OFS_AUTO_PAUSE_TIME, 32'h0000_0abc);
    wr(OFS_PAUSE_RETRY_LIMIT, 32'h0000_0003);
    wr(OFS_PAUSE_STATUS, 32'hffff_ffff);
    rd_chk("threshold", OFS_FLOW_START_THRESHOLD, 32'h0000_0040);
    rd_chk("retry_limit", OFS_PAUSE_RETRY_LIMIT, 32'h0000_0003);
    rd_chk("status_ro", OFS_PAUSE_STATUS, WORD_ZERO);
    tend("registers");
    // level at threshold but auto disabled: only the manual frame
    @(posedge sys_clk);
    level <= 16'h0040;
    man_t = 16'($random(seed));
    wr(OFS_MANUAL_PAUSE_TIME, {16'h0000, man_t});
    exp_q.push_back(man_t);
    wait_cyc(60);
    check_frames();
    tend("manual");
    // one below threshold: nothing; at threshold: exactly the limit
    @(posedge sys_clk);
    level <= 16'h003f;
    wr(OFS_MAC_MODE_CONTROL, 32'h0000_0001);
    wait_cyc(40);
    check_frames();
    @(posedge sys_clk);
    level <= 16'h0040;
    repeat (3) exp_q.push_back(16'h0abc);
    wait_cyc(200);
    check_frames();
    rd_chk("halted", OFS_PAUSE_STATUS, 32'h0003_0004);
    tend("auto_limit");
    // unlimited repeats stop once the fifo drains below threshold
    @(posedge sys_clk);
    level <= 16'h0000;
    wr(OFS_PAUSE_RETRY_LIMIT, 32'h0000_0000);
    @(posedge sys_clk);
    level <= 16'hffff;
    for (int k = 0; k < 400 && got_q.size() < 6; k++) begin
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    level <= 16'h003f;
    wait_cyc(20);
    n = got_q.size();
    wait_cyc(100);
    `CHK("repeats", 1'b1, n >= 6)
    `CHK("after_drain", n, got_q.size())
    foreach (got_q[k]) `CHK("auto_time", 16'h0abc, got_q[k])
    got_q.delete();
    tend("auto_repeat");
    // received pause ignored while disabled
    wr(OFS_MAC_MODE_CONTROL, 32'h0000_0000);
    tx_req <= 1'b1;
    u_part.send_pause(16'h0005);
    repeat (10) begin
      @(posedge sys_clk);
      `CHK("hold_disabled", 1'b0, tx_hold)
    end
    tend("rx_disabled");
    // pause arriving mid-frame, at both link speeds
    for (int s = 0; s < 2; s++) begin
      q = s ? 512 : 52;
      pt = 16'(2 - s);
      wr(OFS_MAC_MODE_CONTROL, s ? 32'h0000_0002 : 32'h0000_0006);
      // wait for a frame start, so the pause lands early in that frame
      for (int k = 0; k < 100 && tx_start !== 1'b1; k++) begin
        @(posedge sys_clk);
      end
      u_part.send_pause(pt);
      @(posedge sys_clk);
      `CHK("busy_kept", 1'b1, tx_busy)
      cnt = 0;
      bad = 0;
      while (tx_hold === 1'b1 && cnt < 2000) begin
        cnt++;
        if (tx_start !== 1'b0) bad++;
        @(posedge sys_clk);
      end
      `CHK("hold_len", 1'b1, cnt >= pt * q - 1 && cnt <= pt * q + 1)
      `CHK("start_blocked", 0, bad)
      `CHK("start_after", 1'b1, tx_start)
    end
    tend("rx_pause");
    summarize();
  end
endmodule : mac_pause_flow_control_tb_top
